/* src/uetx_defines.vh */
// constants for the usb endpoint transaction handler
`ifndef UETX_DEFINES_VH
`define UETX_DEFINES_VH
// register offsets (word index * 4)
`define UETX_CSR_OFS 8'h00
`define UETX_FDR_OFS 8'h04
`define UETX_CFG_OFS 8'h08
`define UETX_IER_OFS 8'h0c
`define UETX_STAT_OFS 8'h10
// control/status field positions
`define UETX_CSR_SETUP 0
`define UETX_CSR_TXRDY 1
`define UETX_CSR_TXCMP 2
`define UETX_CSR_RXBK0 3
`define UETX_CSR_STALL 4
`define UETX_CSR_CNT_LO 16
// bus-side token kinds
`define UETX_TOK_SETUP 2'h0
`define UETX_TOK_IN 2'h1
`define UETX_TOK_OUT 2'h2
// handshake codes and setup packet length
`define UETX_HS_NONE 2'h0
`define UETX_HS_ACK 2'h1
`define UETX_HS_NAK 2'h2
`define UETX_HS_STALL 2'h3
`define UETX_SETUP_LEN 4'h8
`endif

/* src/uetx_handler.v */
// single-bank endpoint transaction handler, bus side and register side
`timescale 1ns/1ps
//
// Behaviour
// - endpoint number zero is the default control endpoint, always control capable.
// - only setup, data in and data out token kinds are handled.
// - control sequence setup, optional data, then opposite-direction status stage.
// - control transfers only accepted while the dual-bank attribute is off.
// - isochronous traffic only accepted while the dual-bank attribute is on.
// - software stall bit makes the device answer in and out tokens with stall; setup tokens still go through and clear it.
// - status in stage sends a zero-length packet with data1 pid.
// - setup packets are acknowledged automatically without firmware.
// - setup reception sets setup flag and stores bytes in the fifo.
// - setup flag holds interrupt pending, gated by endpoint interrupt enable.
// - request arguments come in data out, answers in the next data in.
// - setting packet-ready hands the fifo to the device for sending.
// - host ack on data in sets transmit-complete and frees the fifo.
// - transmit-complete held set keeps the interrupt pending.
// - data out gets nak while processor owns fifo or packet-ready is set, else ack.
// - received byte count is reported after an out payload.
`include "uetx_defines.vh"
module uetx_handler #(
  parameter DEPTH = 8,
  parameter AW = 3,
  parameter EP_NUM = 4'h0
) (
  input wire clk_in,
  input wire rst_in,
  // register port
  input wire [7:0] addr_in,
  input wire [31:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [31:0] rdata_out,
  output reg irq_out,
  // bus side: token, data and handshake strobes to and from the serial engine
  input wire tok_valid_in,
  input wire [1:0] tok_kind_in,
  input wire [3:0] tok_ep_in,
  input wire rx_byte_valid_in,
  input wire [7:0] rx_byte_in,
  input wire rx_end_in,
  input wire host_ack_in,
  input wire tx_byte_ready_in,
  output reg [1:0] hs_out,
  output reg hs_valid_out,
  output reg tx_valid_out,
  output reg [7:0] tx_byte_out,
  output reg tx_last_out,
  output reg tx_zlp_out,
  output reg tx_data1_out
);
////////////////////////////////////////////////////////////////////////
// synchronisers for the bus-side inputs
reg [6:0] s1_q;
reg [6:0] s2_q;
reg [7:0] rb1_q;
reg [7:0] rb2_q;
reg [1:0] tk1_q;
reg [1:0] tk2_q;
reg [3:0] ep1_q;
reg [3:0] ep2_q;
always @(posedge clk_in) begin
  if (rst_in) begin
    s1_q <= 7'h00;
    s2_q <= 7'h00;
    rb1_q <= 8'h00;
    rb2_q <= 8'h00;
    tk1_q <= 2'h0;
    tk2_q <= 2'h0;
    ep1_q <= 4'h0;
    ep2_q <= 4'h0;
  end else begin
    s1_q <= {tx_byte_ready_in, host_ack_in, rx_end_in, rx_byte_valid_in, tok_valid_in, 2'b00};
    s2_q <= s1_q;
    rb1_q <= rx_byte_in;
    rb2_q <= rb1_q;
    tk1_q <= tok_kind_in;
    tk2_q <= tk1_q;
    ep1_q <= tok_ep_in;
    ep2_q <= ep1_q;
  end
end
wire tok_v = s2_q[2];
wire rxb_v = s2_q[3];
wire rx_end = s2_q[4];
wire hack = s2_q[5];
wire txrdy_in = s2_q[6];
////////////////////////////////////////////////////////////////////////
// state
localparam ST_IDLE = 3'h0;
localparam ST_RXSET = 3'h1;
localparam ST_RXOUT = 3'h2;
localparam ST_TX = 3'h3;
localparam ST_WACK = 3'h4;
localparam ST_DROP = 3'h5;
reg [2:0] st_q;
reg [7:0] fifo_q [0:DEPTH-1];
reg [AW-1:0] wp_q;
reg [AW-1:0] rp_q;
reg [AW:0] cnt_q;
reg setup_q;
reg txrdy_q;
reg txcmp_q;
reg rxbk0_q;
reg stall_q;
reg dual_q;
reg iso_q;
reg ctl_q;
reg ie_q;
reg status_in_q;
reg dir_in_q;
reg data1_q;
reg [AW:0] rxcnt_q;
reg [AW:0] txn_q;
wire ep_hit = (ep2_q == EP_NUM[3:0]);
wire ctl_ok = ctl_q & ~dual_q;
wire iso_ok = ~iso_q | dual_q;
wire csr_wr = wr_in & (addr_in == `UETX_CSR_OFS);
wire fdr_wr = wr_in & (addr_in == `UETX_FDR_OFS);
wire fdr_rd = rd_in & (addr_in == `UETX_FDR_OFS);
// decode for a csr write that clears a flag
function clr_bit;
  input wr;
  input [31:0] d;
  input integer pos;
  begin
    clr_bit = wr & ~d[pos];
  end
endfunction
////////////////////////////////////////////////////////////////////////
// transaction engine and flags
integer i;
always @(posedge clk_in) begin
  if (rst_in) begin
    st_q <= ST_IDLE;
    for (i = 0; i < DEPTH; i = i + 1) begin
      fifo_q[i] <= 8'h00;
    end
    wp_q <= {AW{1'b0}};
    rp_q <= {AW{1'b0}};
    cnt_q <= {(AW+1){1'b0}};
    setup_q <= 1'b0;
    txrdy_q <= 1'b0;
    txcmp_q <= 1'b0;
    rxbk0_q <= 1'b0;
    stall_q <= 1'b0;
    dual_q <= 1'b0;
    iso_q <= 1'b0;
    ctl_q <= (EP_NUM == 0);
    ie_q <= 1'b0;
    status_in_q <= 1'b0;
    dir_in_q <= 1'b0;
    data1_q <= 1'b0;
    rxcnt_q <= {(AW+1){1'b0}};
    txn_q <= {(AW+1){1'b0}};
    hs_out <= `UETX_HS_NONE;
    hs_valid_out <= 1'b0;
    tx_valid_out <= 1'b0;
    tx_byte_out <= 8'h00;
    tx_last_out <= 1'b0;
    tx_zlp_out <= 1'b0;
    tx_data1_out <= 1'b0;
    irq_out <= 1'b0;
  end else begin
    hs_valid_out <= 1'b0;
    tx_valid_out <= 1'b0;
    tx_last_out <= 1'b0;
    tx_zlp_out <= 1'b0;
    // software side
    if (wr_in && addr_in == `UETX_CFG_OFS) begin
      dual_q <= wdata_in[0];
      iso_q <= wdata_in[1];
      ctl_q <= wdata_in[2] | (EP_NUM == 0);
    end
    if (wr_in && addr_in == `UETX_IER_OFS) begin
      ie_q <= wdata_in[0];
    end
    if (csr_wr) begin
      stall_q <= wdata_in[`UETX_CSR_STALL];
      if (wdata_in[`UETX_CSR_TXRDY] && st_q != ST_TX && st_q != ST_WACK) begin
        txrdy_q <= 1'b1;
      end
    end
    if (clr_bit(csr_wr, wdata_in, `UETX_CSR_SETUP)) setup_q <= 1'b0;
    if (clr_bit(csr_wr, wdata_in, `UETX_CSR_TXCMP)) txcmp_q <= 1'b0;
    if (clr_bit(csr_wr, wdata_in, `UETX_CSR_RXBK0)) rxbk0_q <= 1'b0;
    if (fdr_wr && !txrdy_q && cnt_q != DEPTH) begin
      fifo_q[wp_q] <= wdata_in[7:0];
      wp_q <= wp_q + 1'b1;
      cnt_q <= cnt_q + 1'b1;
    end
    if (fdr_rd && cnt_q != 0 && st_q == ST_IDLE) begin
      rp_q <= rp_q + 1'b1;
      cnt_q <= cnt_q - 1'b1;
    end
    // bus side
    case (st_q)
      ST_IDLE: begin
        if (tok_v && ep_hit) begin
          if (stall_q && tk2_q != `UETX_TOK_SETUP) begin
            hs_out <= `UETX_HS_STALL;
            hs_valid_out <= 1'b1;
            st_q <= (tk2_q == `UETX_TOK_OUT) ? ST_DROP : ST_IDLE;
          end else if (tk2_q == `UETX_TOK_SETUP) begin
            if (ctl_ok) begin
              wp_q <= {AW{1'b0}};
              rp_q <= {AW{1'b0}};
              cnt_q <= {(AW+1){1'b0}};
              txrdy_q <= 1'b0;
              stall_q <= 1'b0;
              st_q <= ST_RXSET;
            end else begin
              st_q <= ST_DROP;
            end
          end else if (tk2_q == `UETX_TOK_IN) begin
            if (!iso_ok) begin
              st_q <= ST_IDLE;
            end else if (txrdy_q) begin
              txn_q <= cnt_q;
              tx_data1_out <= data1_q | status_in_q;
              st_q <= ST_TX;
            end else if (status_in_q) begin
              tx_zlp_out <= 1'b1;
              tx_data1_out <= 1'b1;
              tx_valid_out <= 1'b1;
              tx_last_out <= 1'b1;
              st_q <= ST_WACK;
            end else begin
              hs_out <= `UETX_HS_NAK;
              hs_valid_out <= 1'b1;
            end
          end else if (tk2_q == `UETX_TOK_OUT) begin
            if (!iso_ok || rxbk0_q || setup_q || txrdy_q) begin
              hs_out <= `UETX_HS_NAK;
              hs_valid_out <= 1'b1;
              st_q <= ST_DROP;
            end else begin
              wp_q <= {AW{1'b0}};
              rp_q <= {AW{1'b0}};
              cnt_q <= {(AW+1){1'b0}};
              st_q <= ST_RXOUT;
            end
          end
        end
      end
      ST_RXSET, ST_RXOUT: begin
        if (rxb_v && cnt_q != DEPTH) begin
          fifo_q[wp_q] <= rb2_q;
          // request direction sits in the first setup byte
          if (st_q == ST_RXSET && cnt_q == 0) dir_in_q <= rb2_q[7];
          wp_q <= wp_q + 1'b1;
          cnt_q <= cnt_q + 1'b1;
        end
        if (rx_end) begin
          hs_out <= `UETX_HS_ACK;
          hs_valid_out <= 1'b1;
          st_q <= ST_IDLE;
          if (st_q == ST_RXSET) begin
            setup_q <= 1'b1;
            status_in_q <= 1'b0;
            data1_q <= 1'b1;
          end else begin
            rxbk0_q <= 1'b1;
            rxcnt_q <= cnt_q;
            if (ctl_q && !dir_in_q) status_in_q <= 1'b1;
            if (ctl_q && cnt_q == 0) status_in_q <= 1'b0;
          end
        end
      end
      ST_TX: begin
        if (txn_q == 0) begin
          tx_zlp_out <= 1'b1;
          tx_valid_out <= 1'b1;
          tx_last_out <= 1'b1;
          st_q <= ST_WACK;
        end else if (txrdy_in) begin
          tx_byte_out <= fifo_q[rp_q];
          tx_valid_out <= 1'b1;
          tx_last_out <= (txn_q == 1);
          rp_q <= rp_q + 1'b1;
          txn_q <= txn_q - 1'b1;
          if (txn_q == 1) st_q <= ST_WACK;
        end
      end
      ST_WACK: begin
        if (hack) begin
          txcmp_q <= 1'b1;
          txrdy_q <= 1'b0;
          data1_q <= ~data1_q;
          wp_q <= {AW{1'b0}};
          rp_q <= {AW{1'b0}};
          cnt_q <= {(AW+1){1'b0}};
          if (status_in_q) status_in_q <= 1'b0;
          if (ctl_q && dir_in_q) status_in_q <= 1'b0;
          st_q <= ST_IDLE;
        end else if (tok_v) begin
          rp_q <= {AW{1'b0}};
          st_q <= ST_IDLE; // no ack: keep data for a retry
        end
      end
      ST_DROP: begin
        if (rx_end) st_q <= ST_IDLE;
      end
      default: st_q <= ST_IDLE;
    endcase
    irq_out <= ie_q & (setup_q | txcmp_q | rxbk0_q);
    if (rd_in) begin
      case (addr_in)
        `UETX_CSR_OFS: rdata_out <= {{(16-AW-1){1'b0}}, rxcnt_q, 11'h000, stall_q, rxbk0_q, txcmp_q, txrdy_q, setup_q};
        `UETX_FDR_OFS: rdata_out <= {24'h000000, fifo_q[rp_q]};
        `UETX_CFG_OFS: rdata_out <= {29'h0, ctl_q, iso_q, dual_q};
        `UETX_IER_OFS: rdata_out <= {31'h0, ie_q};
        `UETX_STAT_OFS: rdata_out <= {26'h0, status_in_q, dir_in_q, data1_q, st_q};
        default: rdata_out <= 32'h00000000;
      endcase
    end else begin
      rdata_out <= 32'h00000000;
    end
  end
end
endmodule // uetx_handler

/* testbench/uetx_handler_props.sv */
// port assertions for the endpoint transaction handler
`timescale 1ns/1ps
`include "uetx_defines.vh"
module uetx_handler_props (
  input wire clk_in,
  input wire rst_in,
  input wire [7:0] addr_in,
  input wire [31:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  input wire [31:0] rdata_out,
  input wire irq_out,
  input wire tok_valid_in,
  input wire [1:0] tok_kind_in,
  input wire rx_end_in,
  input wire host_ack_in,
  input wire [1:0] hs_out,
  input wire hs_valid_out,
  input wire tx_valid_out,
  input wire tx_last_out,
  input wire tx_zlp_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  reg ie_q;
  reg stp_q;
  reg sent_q;
  always @(posedge clk_in) begin
    if (rst_in) begin
      ie_q <= 1'b0;
      stp_q <= 1'b0;
      sent_q <= 1'b0;
    end else begin
      if (wr_in && addr_in == `UETX_IER_OFS) ie_q <= wdata_in[0];
      if (tok_valid_in) stp_q <= (tok_kind_in == `UETX_TOK_SETUP);
      sent_q <= (sent_q | tx_last_out) & ~host_ack_in;
    end
  end
  sequence s_setup_end;
    stp_q && rx_end_in;
  endsequence
  sequence s_ack;
    hs_valid_out && hs_out == `UETX_HS_ACK;
  endsequence
  property p_setup_ack;
    s_setup_end |-> ##3 s_ack;
  endproperty
  a_setup_ack: assert property (p_setup_ack) else $error("setup not acked");
  property p_setup_irq;
    s_setup_end ##0 ie_q |-> ##[3:6] irq_out;
  endproperty
  a_setup_irq: assert property (p_setup_irq) else $error("no irq on setup");
  property p_irq_mask;
    !ie_q && !$past(ie_q) |-> !irq_out;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq while disabled");
  property p_irq_hold;
    irq_out && !wr_in && !$past(wr_in) |=> irq_out;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
  property p_txcmp_irq;
    sent_q && host_ack_in && ie_q |-> ##[2:8] irq_out;
  endproperty
  a_txcmp_irq: assert property (p_txcmp_irq) else $error("no irq on tx done");
  property p_rd_zero;
    !$past(rd_in) |-> rdata_out == 32'h0;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("read data outside slot");
  property p_hs_pulse;
    hs_valid_out |=> !hs_valid_out;
  endproperty
  a_hs_pulse: assert property (p_hs_pulse) else $error("handshake too long");
  property p_hs_code;
    hs_valid_out |-> hs_out != `UETX_HS_NONE;
  endproperty
  a_hs_code: assert property (p_hs_code) else $error("empty handshake");
  property p_zlp;
    tx_zlp_out |-> tx_last_out;
  endproperty
  a_zlp: assert property (p_zlp) else $error("empty packet not closed");
  property p_last;
    tx_last_out |-> tx_valid_out;
  endproperty
  a_last: assert property (p_last) else $error("last without byte");
endmodule // uetx_handler_props
bind uetx_handler uetx_handler_props chk_u (.*);

/* testbench/uetx_host_model.sv */
// host and serial engine model for the bus side
`timescale 1ns/1ps
module uetx_host_model (
  input wire clk_in,
  output reg tok_valid_out,
  output reg [1:0] tok_kind_out,
  output reg [3:0] tok_ep_out,
  output reg rx_byte_valid_out,
  output reg [7:0] rx_byte_out,
  output reg rx_end_out,
  output reg host_ack_out,
  output reg tx_byte_ready_out,
  input wire [1:0] hs_in,
  input wire hs_valid_in,
  input wire tx_valid_in,
  input wire [7:0] tx_byte_in,
  input wire tx_last_in,
  input wire tx_zlp_in,
  input wire tx_data1_in
);
  reg [1:0] hs_q;
  reg [7:0] last_q;
  reg zlp_q;
  reg d1_q;
  reg slow;
  reg [3:0] ep_sel;
  integer n_tx;
  integer n_evt;
  initial begin
    {tok_valid_out, tok_kind_out, tok_ep_out, rx_byte_valid_out, rx_byte_out, rx_end_out, host_ack_out} = 0;
    {tx_byte_ready_out, hs_q, last_q, zlp_q, d1_q, slow, ep_sel} = 0;
    n_tx = 0;
    n_evt = 0;
  end
  always @(posedge clk_in) begin
    if (hs_valid_in) hs_q <= hs_in;
    if (tx_valid_in) n_tx <= n_tx + 1;
    if (tx_valid_in) last_q <= tx_byte_in;
    if (tx_zlp_in) zlp_q <= 1'b1;
    if (tx_zlp_in) d1_q <= tx_data1_in;
    if (hs_valid_in | tx_last_in | tx_zlp_in) n_evt <= n_evt + 1;
    tx_byte_ready_out <= slow ? ~tx_byte_ready_out : 1'b1;
  end
  // token for the endpoint in ep_sel, then payload and end for setup or out
  task send(input [1:0] kind, input integer n, input [7:0] base);
    integer i;
    @(posedge clk_in);
    tok_valid_out <= 1'b1;
    tok_kind_out <= kind;
    tok_ep_out <= ep_sel;
    @(posedge clk_in);
    tok_valid_out <= 1'b0;
    if (kind != 2'h1) begin
      for (i = 0; i < n; i = i + 1) begin
        @(posedge clk_in);
        rx_byte_valid_out <= 1'b1;
        rx_byte_out <= base + i[7:0];
        @(posedge clk_in);
        rx_byte_valid_out <= 1'b0;
        rx_byte_out <= ~(base + i[7:0]);
      end
      @(posedge clk_in);
      rx_end_out <= 1'b1;
      @(posedge clk_in);
      rx_end_out <= 1'b0;
    end
  endtask
  task ack;
    @(posedge clk_in);
    host_ack_out <= 1'b1;
    @(posedge clk_in);
    host_ack_out <= 1'b0;
  endtask
endmodule // uetx_host_model

/* testbench/tb_top.sv */
// self-checking bench for the endpoint transaction handler
`timescale 1ns/1ps
`include "uetx_defines.vh"
module tb_top;
  reg clk_in, rst_in, wr_in, rd_in;
  reg [7:0] addr_in;
  reg [31:0] wdata_in, rv;
  wire [31:0] rdata_out;
  wire irq_out, tv, rbv, re, ha, tbr, hsv, txv, txl, txz, txd;
  wire [1:0] tk, hs;
  wire [7:0] rb, txb;
  wire [3:0] tep;
  integer errors, n_checks, i, k, e0, n0;
  uetx_handler dut_u (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .irq_out(irq_out), .tok_valid_in(tv),
    .tok_kind_in(tk), .tok_ep_in(tep), .rx_byte_valid_in(rbv), .rx_byte_in(rb), .rx_end_in(re),
    .host_ack_in(ha), .tx_byte_ready_in(tbr), .hs_out(hs), .hs_valid_out(hsv), .tx_valid_out(txv),
    .tx_byte_out(txb), .tx_last_out(txl), .tx_zlp_out(txz), .tx_data1_out(txd));
  uetx_host_model host_u (.clk_in(clk_in), .tok_valid_out(tv), .tok_kind_out(tk), .rx_byte_valid_out(rbv),
    .tok_ep_out(tep), .rx_byte_out(rb), .rx_end_out(re), .host_ack_out(ha), .tx_byte_ready_out(tbr), .hs_in(hs),
    .hs_valid_in(hsv), .tx_valid_in(txv), .tx_byte_in(txb), .tx_last_in(txl), .tx_zlp_in(txz),
    .tx_data1_in(txd));
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  task chk(input [31:0] seen, input [31:0] exp, input [63:0] nm);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("[ERR] %0s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task rd(input [7:0] a);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 rv = rdata_out;
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // token with bounded wait for a handshake or packet end
  task xfer(input [1:0] kind, input integer n, input [7:0] base);
    e0 = host_u.n_evt;
    host_u.send(kind, n, base);
    for (i = 0; i < 300 && host_u.n_evt == e0; i = i + 1) @(posedge clk_in);
    if (i == 300) begin
      errors = errors + 1;
      give_verdict;
    end
  endtask
  initial begin
    rst_in = 1'b1;
    wr_in = 1'b0;
    rd_in = 1'b0;
    addr_in = 8'h00;
    wdata_in = 32'h00000000;
    errors = 0;
    n_checks = 0;
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(`UETX_CSR_OFS);
    chk(rv, 0, "csr rst");
    rd(8'h1c);
    chk(rv, 0, "unmap");
    wr(`UETX_IER_OFS, 1);
    wr(`UETX_CFG_OFS, 32'h4);
    xfer(`UETX_TOK_SETUP, 8, 8'h40);
    chk(host_u.hs_q, `UETX_HS_ACK, "stp ack");
    rd(`UETX_CSR_OFS);
    chk(rv[0], 1, "setup");
    chk(irq_out, 1, "irq");
    for (k = 0; k < 8; k = k + 1) begin
      rd(`UETX_FDR_OFS);
      chk(rv[7:0], 8'h40 + k[7:0], "stp byte");
    end
    xfer(`UETX_TOK_OUT, 2, 8'h10);
    chk(host_u.hs_q, `UETX_HS_NAK, "out nak");
    wr(`UETX_IER_OFS, 0);
    repeat (3) @(posedge clk_in);
    chk(irq_out, 0, "masked");
    wr(`UETX_IER_OFS, 1);
    wr(`UETX_CSR_OFS, 0);
    xfer(`UETX_TOK_OUT, 3, 8'h20);
    chk(host_u.hs_q, `UETX_HS_ACK, "out ack");
    rd(`UETX_CSR_OFS);
    chk(rv[19:16], 3, "rx cnt");
    chk(rv[3], 1, "rx full");
    wr(`UETX_CSR_OFS, 0);
    xfer(`UETX_TOK_IN, 0, 0);
    chk({host_u.zlp_q, host_u.d1_q}, 2'h3, "stat zlp");
    host_u.ack;
    xfer(`UETX_TOK_IN, 0, 0);
    chk(host_u.hs_q, `UETX_HS_NAK, "in nak");
    rd(`UETX_CSR_OFS);
    chk(rv[1], 0, "rdy clr");
    for (k = 0; k < 4; k = k + 1) wr(`UETX_FDR_OFS, 8'h30 + k[7:0]);
    wr(`UETX_CSR_OFS, 2);
    host_u.slow = 1'b1;
    n0 = host_u.n_tx;
    xfer(`UETX_TOK_IN, 0, 0);
    chk(host_u.n_tx - n0, 4, "tx count");
    chk(host_u.last_q, 8'h33, "tx last");
    host_u.ack;
    repeat (8) @(posedge clk_in);
    rd(`UETX_CSR_OFS);
    chk(rv[2:0], 3'h4, "tx done");
    chk(irq_out, 1, "tx irq");
    wr(`UETX_CSR_OFS, 0);
    repeat (4) @(posedge clk_in);
    chk(irq_out, 0, "tx clr");
    wr(`UETX_CSR_OFS, 32'h10);
    xfer(`UETX_TOK_IN, 0, 0);
    chk(host_u.hs_q, `UETX_HS_STALL, "in stall");
    xfer(`UETX_TOK_OUT, 1, 8'h40);
    chk(host_u.hs_q, `UETX_HS_STALL, "outstall");
    wr(`UETX_CFG_OFS, 32'h6);
    wr(`UETX_CSR_OFS, 0);
    e0 = host_u.n_evt;
    host_u.send(`UETX_TOK_IN, 0, 0);
    repeat (8) @(posedge clk_in);
    chk(host_u.n_evt - e0, 0, "iso drop");
    host_u.ep_sel = 4'h1;
    wr(`UETX_CFG_OFS, 32'h4);
    host_u.send(`UETX_TOK_IN, 0, 0);
    repeat (8) @(posedge clk_in);
    chk(host_u.n_evt - e0, 0, "other ep");
    give_verdict;
  end
endmodule // tb_top
